// ### mgs_pkg.sv
// Package for the general status word block: offsets, bit positions,
// reset values and the carrier structs shared by the design files.
// Assumes a 16-bit register port with byte-sized addresses.
package mgs_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0]  GSW_ADDR      = 8'h1f; // General status word
    localparam logic [7:0]  ALARM_ADDR    = 8'h1e; // Alarm status word
    localparam logic [7:0]  IRQ_STAT_ADDR = 8'h40; // Interrupt status
    localparam logic [7:0]  IRQ_MASK_ADDR = 8'h41; // Interrupt mask
    localparam logic [15:0] GSW_RESET     = 16'h0000;
    localparam logic [15:0] ALARM_RESET   = 16'h0000;
    localparam logic [5:0]  IRQ_RESET     = 6'h00;

    // ********************************************************
    // Field positions of the general status word
    // ********************************************************
    localparam int GLOBAL_BIT   = 15;
    localparam int ARMED_BIT    = 14;
    localparam int SRC_HI_BIT   = 13;
    localparam int SRC_LO_BIT   = 8;
    localparam int RSV_HI_BIT   = 7;
    localparam int RSV_LO_BIT   = 4;
    localparam int STBY2_BIT    = 3;
    localparam int STBY1_BIT    = 2;
    localparam int AMP_BIT      = 1;
    localparam int ALARM_BIT    = 0;

    // Interrupt status bit positions
    localparam int IRQ_GLOBAL   = 0;
    localparam int IRQ_ARMED    = 1;
    localparam int IRQ_ALARM    = 2;
    localparam int IRQ_STBY1    = 3;
    localparam int IRQ_STBY2    = 4;
    localparam int IRQ_AMP      = 5;
    localparam int IRQ_W        = 6;

    // Number of direct-mode sources
    localparam int SRC_N        = 6;

    // Register port request carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mgs_req_t;

    // Converter status carrier
    typedef struct packed {
        logic              powered;   // Converter powered
        logic              chan_sel;  // At least one channel selected
        logic              halt_wr;   // Pulse: halting register write
        logic              busy;      // Change still being applied
        logic              running;   // Triggered run in progress
        logic [SRC_N-1:0]  src_dav;   // Direct-mode result flags
    } mgs_conv_t;

endpackage

// ### mgs_sync.sv
// Two flip-flop synchroniser for pin levels entering the core clock.
// Assumes the input is asynchronous to clk and changes slowly.
`timescale 1ns/1ps
module mgs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;

    // First stage feeds the second only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

// ### mgs_status.sv
// General status word of the monitor-and-control core.
// Assumes the converter sequencer and the alarm comparators live outside
// on clk; standby and amplifier-enable pins are asynchronous.
`timescale 1ns/1ps

// Behaviour
// - Bit 15 shows global new-results flag for software polling.
// - Armed flag reads 0 until converter powered and channel selected.
// - Halting writes drop armed until change applied, then return to 1.
// - Armed is 0 during a triggered run, 1 once stopped.
// - Bits 13..8: local, remote2, remote1, internal, external, current.
// - Bits 7..4 always read zero.
// - Bits 3 and 2 mirror standby pin 2 and standby pin 1.
// - Bit 1 shows amplifier-enable pin: 1 on, 0 off.
// - Bit 0 is OR of all alarm status bits.
// - Global alarm sticks until alarm status word is read.
// - Status word sits at address 0x1F, reset value 0x0000.
module mgs_status (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire mgs_pkg::mgs_req_t req,
    output logic [15:0]            rdata,
    input  wire mgs_pkg::mgs_conv_t conv,
    input  wire logic [15:0]       alarm_word,
    input  wire logic              standby_pin1,
    input  wire logic              standby_pin2,
    input  wire logic              amp_enable_pin,
    output logic                   irq
);

    // ********************************************************
    // Pin synchronisation
    // ********************************************************
    logic [2:0] pins_s;

    mgs_sync #(
        .W(3)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({amp_enable_pin, standby_pin2, standby_pin1}),
        .dout (pins_s)
    );

    logic standby_pin1_level;
    logic standby_pin2_level;
    logic amp_enable_pin_level;

    // Synchronised pin levels
    assign standby_pin1_level   = pins_s[0];
    assign standby_pin2_level   = pins_s[1];
    assign amp_enable_pin_level = pins_s[2];

    // ********************************************************
    // Converter armed flag
    // ********************************************************
    typedef enum logic [1:0] {
        MGS_IDLE  = 2'b00,
        MGS_ARMED = 2'b01,
        MGS_APPLY = 2'b10,
        MGS_RUN   = 2'b11
    } mgs_arm_t;

    mgs_arm_t arm_q;
    mgs_arm_t arm_d;
    logic     ready_cond;

    assign ready_cond = conv.powered & conv.chan_sel;

    // Armed state transitions
    always_comb begin
        arm_d = arm_q;
        unique case (arm_q)
            MGS_IDLE: begin
                if (ready_cond && !conv.running && !conv.busy) begin
                    arm_d = MGS_ARMED;
                end
            end
            MGS_ARMED: begin
                if (!ready_cond) begin
                    arm_d = MGS_IDLE;
                end else if (conv.halt_wr || conv.busy) begin
                    arm_d = MGS_APPLY;
                end else if (conv.running) begin
                    arm_d = MGS_RUN;
                end
            end
            MGS_APPLY: begin
                if (!conv.busy && !conv.halt_wr) begin
                    arm_d = ready_cond ? MGS_ARMED : MGS_IDLE;
                end
            end
            MGS_RUN: begin
                if (conv.halt_wr || conv.busy) begin
                    arm_d = MGS_APPLY;
                end else if (!conv.running) begin
                    arm_d = ready_cond ? MGS_ARMED : MGS_IDLE;
                end
            end
        endcase
    end

    // Armed state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arm_q <= MGS_IDLE;
        end else begin
            arm_q <= arm_d;
        end
    end

    logic armed_flag;
    assign armed_flag = (arm_q == MGS_ARMED);

    // ********************************************************
    // Sticky global alarm
    // ********************************************************
    logic alarm_any;
    logic global_alarm_bit_q;
    logic alarm_rd;

    assign alarm_any = |alarm_word;
    assign alarm_rd  = req.rd && (req.addr == mgs_pkg::ALARM_ADDR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_alarm_bit_q <= 1'b0;
        end else if (alarm_any) begin
            global_alarm_bit_q <= 1'b1;
        end else if (alarm_rd) begin
            global_alarm_bit_q <= 1'b0;
        end
    end

    // ********************************************************
    // Status word assembly
    // ********************************************************
    logic [15:0] gsw_d;
    logic [15:0] gsw_q;

    // Gather fields into the word
    always_comb begin
        gsw_d = mgs_pkg::GSW_RESET;
        gsw_d[mgs_pkg::GLOBAL_BIT] = |conv.src_dav;
        gsw_d[mgs_pkg::ARMED_BIT]  = armed_flag;
        gsw_d[mgs_pkg::SRC_HI_BIT:mgs_pkg::SRC_LO_BIT] = conv.src_dav;
        gsw_d[mgs_pkg::RSV_HI_BIT:mgs_pkg::RSV_LO_BIT] = 4'h0;
        gsw_d[mgs_pkg::STBY2_BIT] = standby_pin2_level;
        gsw_d[mgs_pkg::STBY1_BIT] = standby_pin1_level;
        gsw_d[mgs_pkg::AMP_BIT]   = amp_enable_pin_level;
        gsw_d[mgs_pkg::ALARM_BIT] = global_alarm_bit_q | alarm_any;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gsw_q <= mgs_pkg::GSW_RESET;
        end else begin
            gsw_q <= gsw_d;
        end
    end

    // ********************************************************
    // Interrupt status and mask
    // ********************************************************
    logic [mgs_pkg::IRQ_W-1:0] irq_stat_q;
    logic [mgs_pkg::IRQ_W-1:0] irq_mask_q;
    logic [mgs_pkg::IRQ_W-1:0] irq_evt;
    logic [15:0]               gsw_prev_q;
    logic                      stat_wr;
    logic                      mask_wr;

    assign stat_wr = req.wr && (req.addr == mgs_pkg::IRQ_STAT_ADDR);
    assign mask_wr = req.wr && (req.addr == mgs_pkg::IRQ_MASK_ADDR);

    // Previous word for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gsw_prev_q <= mgs_pkg::GSW_RESET;
        end else begin
            gsw_prev_q <= gsw_q;
        end
    end

    // Events: rising results, armed, alarm; any change of pins
    always_comb begin
        irq_evt = '0;
        irq_evt[mgs_pkg::IRQ_GLOBAL] = gsw_q[mgs_pkg::GLOBAL_BIT] &
                                       ~gsw_prev_q[mgs_pkg::GLOBAL_BIT];
        irq_evt[mgs_pkg::IRQ_ARMED]  = gsw_q[mgs_pkg::ARMED_BIT] &
                                       ~gsw_prev_q[mgs_pkg::ARMED_BIT];
        irq_evt[mgs_pkg::IRQ_ALARM]  = gsw_q[mgs_pkg::ALARM_BIT] &
                                       ~gsw_prev_q[mgs_pkg::ALARM_BIT];
        irq_evt[mgs_pkg::IRQ_STBY1]  = gsw_q[mgs_pkg::STBY1_BIT] ^
                                       gsw_prev_q[mgs_pkg::STBY1_BIT];
        irq_evt[mgs_pkg::IRQ_STBY2]  = gsw_q[mgs_pkg::STBY2_BIT] ^
                                       gsw_prev_q[mgs_pkg::STBY2_BIT];
        irq_evt[mgs_pkg::IRQ_AMP]    = gsw_q[mgs_pkg::AMP_BIT] ^
                                       gsw_prev_q[mgs_pkg::AMP_BIT];
    end

    // Sticky status, write one clears, new event wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= mgs_pkg::IRQ_RESET;
        end else if (stat_wr) begin
            irq_stat_q <= (irq_stat_q &
                           ~req.wdata[mgs_pkg::IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // Mask register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= mgs_pkg::IRQ_RESET;
        end else if (mask_wr) begin
            irq_mask_q <= req.wdata[mgs_pkg::IRQ_W-1:0];
        end
    end

    // Level interrupt from unmasked status
    assign irq = |(irq_stat_q & irq_mask_q);

    // ********************************************************
    // Read port
    // ********************************************************
    // decode at 0x1F, 0x1E, 0x40 and 0x41
    // no write path to the word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                mgs_pkg::GSW_ADDR:      rdata <= gsw_q;
                mgs_pkg::ALARM_ADDR:    rdata <= alarm_word;
                mgs_pkg::IRQ_STAT_ADDR: rdata <= {10'h000, irq_stat_q};
                mgs_pkg::IRQ_MASK_ADDR: rdata <= {10'h000, irq_mask_q};
                default:                rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule

// ### mgs_status_assertions.sv
// Checker for the general status word block.
// Bound to mgs_status; sees only its ports, all on clk.
`timescale 1ns/1ps
module mgs_status_assertions (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire mgs_pkg::mgs_req_t  req,
    input  wire logic [15:0]        rdata,
    input  wire mgs_pkg::mgs_conv_t conv,
    input  wire logic [15:0]        alarm_word,
    input  wire logic               standby_pin1,
    input  wire logic               standby_pin2,
    input  wire logic               amp_enable_pin,
    input  wire logic               irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ********************************************************
    // Helper history
    // ********************************************************
    logic        rd_q;
    logic [5:0]  blk_q;
    logic        seen_q;
    logic [3:0]  alm_q;
    logic [3:0]  clr_q;
    logic [24:0] in_q;
    logic [2:0]  qcnt_q;
    // Status read, blocked-arm history, sticky shadow, quiet count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q   <= 1'b0;
            blk_q  <= 6'h3f;
            seen_q <= 1'b0;
            alm_q  <= 4'h0;
            clr_q  <= 4'hf;
            in_q   <= '0;
            qcnt_q <= 3'h0;
        end else begin
            rd_q   <= req.rd && req.addr == mgs_pkg::GSW_ADDR;
            blk_q  <= {blk_q[4:0], !conv.powered || !conv.chan_sel
                       || conv.running || conv.busy || conv.halt_wr};
            seen_q <= (|alarm_word) || (seen_q && !(req.rd
                       && req.addr == mgs_pkg::ALARM_ADDR));
            alm_q  <= {alm_q[2:0], seen_q};
            clr_q  <= {clr_q[2:0], seen_q || (|alarm_word)};
            in_q   <= {conv.src_dav, standby_pin2, standby_pin1,
                       amp_enable_pin, alarm_word};
            qcnt_q <= (in_q != {conv.src_dav, standby_pin2, standby_pin1,
                       amp_enable_pin, alarm_word}) ? 3'h0
                       : (qcnt_q == 3'h7 ? 3'h7 : qcnt_q + 3'h1);
        end
    end
    // Read of the status word, answered one cycle later
    sequence gsw_read_s;
        req.rd && req.addr == mgs_pkg::GSW_ADDR ##1 1'b1;
    endsequence
    rsv_zero_a: assert property (gsw_read_s |-> rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    idle_zero_a: assert property (!$past(req.rd) |-> rdata == 16'h0)
        else $error("read data not zero outside a read");
    src_flags_a: assert property (rd_q && qcnt_q == 3'h7 |->
        rdata[13:8] == conv.src_dav) else $error("source flags wrong");
    global_flag_a: assert property (rd_q && qcnt_q == 3'h7 |->
        rdata[15] == |conv.src_dav) else $error("global flag wrong");
    pin_levels_a: assert property (rd_q && qcnt_q == 3'h7 |->
        rdata[3:1] == {standby_pin2, standby_pin1, amp_enable_pin})
        else $error("pin levels wrong");
    armed_off_a: assert property (rd_q && blk_q == 6'h3f |-> !rdata[14])
        else $error("armed while blocked");
    armed_on_a: assert property (rd_q && blk_q == 6'h0 |-> rdata[14])
        else $error("not armed when free");
    alarm_hold_a: assert property (rd_q && alm_q == 4'hf |-> rdata[0])
        else $error("global alarm lost");
    alarm_clear_a: assert property (rd_q && clr_q == 4'h0 |-> !rdata[0])
        else $error("global alarm without cause");
endmodule

bind mgs_status mgs_status_assertions u_chk (.clk(clk), .rst(rst),
    .req(req), .rdata(rdata), .conv(conv), .alarm_word(alarm_word),
    .standby_pin1(standby_pin1), .standby_pin2(standby_pin2),
    .amp_enable_pin(amp_enable_pin), .irq(irq));

// ### mgs_status_bench.sv
// Self-checking bench for the general status word block.
// Drives every port of mgs_status directly; 200 MHz clock.
`timescale 1ns/1ps
module mgs_status_bench;
    logic               clk;
    logic               rst;
    mgs_pkg::mgs_req_t  req;
    logic [15:0]        rdata;
    mgs_pkg::mgs_conv_t conv;
    logic [15:0]        alarm_word;
    logic               standby_pin1;
    logic               standby_pin2;
    logic               amp_enable_pin;
    logic               irq;
    logic [31:0]        lfsr;
    logic [15:0]        got;
    int                 mismatches;
    int                 num_checks;
    int                 sticky;

    mgs_status u_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .conv(conv), .alarm_word(alarm_word), .standby_pin1(standby_pin1),
        .standby_pin2(standby_pin2), .amp_enable_pin(amp_enable_pin),
        .irq(irq));
    // ********************************************************
    // Model and bus tasks
    // ********************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected status word from the held inputs
    function automatic logic [15:0] model();
        logic arm;
        arm = conv.powered & conv.chan_sel & !conv.running & !conv.busy;
        return {|conv.src_dav, arm, conv.src_dav, 4'h0, standby_pin2,
                standby_pin1, amp_enable_pin, sticky[0]};
    endfunction
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        // Let the landed write settle before anyone looks at outputs
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        if (a == mgs_pkg::ALARM_ADDR) sticky = |alarm_word;
        #1 got = rdata;
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask
    task automatic chk_gsw();
        rd(mgs_pkg::GSW_ADDR);
        cmp("status_word", model(), got);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Clock, sticky alarm shadow and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (|alarm_word) sticky = 1;
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    // Main sequence
    initial begin
        rst = 1'b1; req = '0; conv = '0; alarm_word = 16'h0;
        standby_pin1 = 1'b0; standby_pin2 = 1'b0; amp_enable_pin = 1'b0;
        lfsr = 32'hc9de; sticky = 0; mismatches = 0; num_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_gsw();
        wr(mgs_pkg::GSW_ADDR, 16'hffff);
        chk_gsw();
        for (int i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            conv <= '{lfsr[0], lfsr[1], 1'b0, lfsr[2], lfsr[3], lfsr[9:4]};
            {standby_pin2, standby_pin1, amp_enable_pin} <= lfsr[12:10];
            alarm_word <= (lfsr[31:29] == 3'h0) ? lfsr[28:13] : 16'h0;
            settle();
            chk_gsw();
        end
        // Arm first so that the halting write has something to drop
        @(posedge clk);
        conv <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 6'h0};
        alarm_word <= 16'h0;
        settle();
        chk_gsw();
        @(posedge clk);
        conv <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 6'h0};
        @(posedge clk);
        conv.halt_wr <= 1'b0;
        settle();
        chk_gsw();
        @(posedge clk);
        conv.busy <= 1'b0;
        settle();
        chk_gsw();
        @(posedge clk);
        conv.running <= 1'b1;
        settle();
        chk_gsw();
        @(posedge clk);
        conv.running <= 1'b0;
        alarm_word <= 16'h0400;
        @(posedge clk);
        alarm_word <= 16'h0;
        settle();
        chk_gsw();
        rd(mgs_pkg::ALARM_ADDR);
        cmp("alarm_word", 16'h0000, got);
        settle();
        chk_gsw();
        wr(mgs_pkg::IRQ_STAT_ADDR, 16'h003f);
        wr(mgs_pkg::IRQ_MASK_ADDR, 16'h0004);
        @(posedge clk);
        alarm_word <= 16'h0001;
        @(posedge clk);
        alarm_word <= 16'h0;
        settle();
        cmp("irq", 16'h0001, {15'h0, irq});
        rd(mgs_pkg::IRQ_STAT_ADDR);
        cmp("irq_stat", 16'h0004, got);
        rd(mgs_pkg::IRQ_MASK_ADDR);
        cmp("irq_mask", 16'h0004, got);
        wr(mgs_pkg::IRQ_MASK_ADDR, 16'h0000);
        cmp("irq", 16'h0000, {15'h0, irq});
        wr(mgs_pkg::IRQ_STAT_ADDR, 16'h003f);
        wr(mgs_pkg::IRQ_MASK_ADDR, 16'h0004);
        cmp("irq", 16'h0000, {15'h0, irq});
        rd(8'h7f);
        cmp("unmapped", 16'h0000, got);
        end_sim();
    end
endmodule
